// >>> ufcs_defs.vh
// Constants shared by the frame command slave files
`ifndef UFCS_DEFS_VH
`define UFCS_DEFS_VH
`define UFCS_CLK_MHZ 100
`define UFCS_IDLE_US 15000
`define UFCS_IDLE_W 21
`define UFCS_IDLE_CYC 21'h16e360
`define UFCS_BW_W 17
`define UFCS_TOT_W 21
`define UFCS_SYNC_LAST 4'h8
`define UFCS_DIV_SHIFT 3
`define UFCS_ADDR_RST 3'h0
`define UFCS_CMD_LO2 5'h03
`define UFCS_CMD_TN 5'h04
`define UFCS_CMD_RES 5'h05
`define UFCS_CMD_BC_FIRST 5'h11
`define UFCS_CMD_BC_LAST 5'h14
`define UFCS_OBJ_MIN 8'h01
`define UFCS_OBJ_MAX 8'h08
`define UFCS_OBJ_CAP 4'h8
`define UFCS_TN_MAX 8'h01
`define UFCS_TX_BITS 4'ha
`endif

// >>> ufcs_rx.v
// Byte receiver timed by the measured bit width
`timescale 1ns/1ps
`include "ufcs_defs.vh"
module ufcs_rx (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Line and timing
   input wire en,
   input wire rxd_s,
   input wire [`UFCS_BW_W-1:0] bit_w,
   // Received byte
   output reg [7:0] rx_data_r,
   output reg rx_vld_r,
   output reg rx_ferr_r
);
   localparam S_IDLE = 2'h0;
   localparam S_START = 2'h1;
   localparam S_DATA = 2'h2;
   localparam S_STOP = 2'h3;
   reg [1:0] st_r;
   reg [`UFCS_BW_W-1:0] cnt_r;
   reg [2:0] bit_r;
   reg prev_r;

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= S_IDLE;
         cnt_r <= {`UFCS_BW_W{1'b0}};
         bit_r <= 3'h0;
         prev_r <= 1'b1;
         rx_data_r <= 8'h00;
         rx_vld_r <= 1'b0;
         rx_ferr_r <= 1'b0;
      end
      else
      begin
         rx_vld_r <= 1'b0;
         rx_ferr_r <= 1'b0;
         prev_r <= rxd_s;
         if (!en)
            st_r <= S_IDLE;
         else if (st_r != S_IDLE && cnt_r != {`UFCS_BW_W{1'b0}})
            cnt_r <= cnt_r - 1'b1;
         else
            case (st_r)
               S_IDLE:
                  if (prev_r && !rxd_s)
                  begin
                     cnt_r <= {1'b0, bit_w[`UFCS_BW_W-1:1]};
                     st_r <= S_START;
                  end
               S_START:
                  // A start bit gone high at mid-bit was a glitch
                  if (rxd_s)
                     st_r <= S_IDLE;
                  else
                  begin
                     cnt_r <= bit_w - 1'b1;
                     bit_r <= 3'h0;
                     st_r <= S_DATA;
                  end
               S_DATA:
               begin
                  rx_data_r <= {rxd_s, rx_data_r[7:1]};
                  cnt_r <= bit_w - 1'b1;
                  bit_r <= bit_r + 1'b1;
                  if (bit_r == 3'h7)
                     st_r <= S_STOP;
               end
               default:
               begin
                  // Second stop bit merges with the interfield gap
                  rx_vld_r <= rxd_s;
                  rx_ferr_r <= !rxd_s;
                  st_r <= S_IDLE;
               end
            endcase
      end
   end
endmodule // ufcs_rx

// >>> ufcs_tx.v
// Byte transmitter: start, eight data bits, two stop bits
`timescale 1ns/1ps
`include "ufcs_defs.vh"
module ufcs_tx (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Byte to send
   input wire tx_go,
   input wire [7:0] tx_data,
   input wire [`UFCS_BW_W-1:0] bit_w,
   output reg tx_done_r,
   // Line
   output reg txd_r,
   output reg txd_oe_r
);
   reg [9:0] shift_r;
   reg [3:0] n_r;
   reg [`UFCS_BW_W-1:0] cnt_r;

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         shift_r <= 10'h3ff;
         n_r <= 4'h0;
         cnt_r <= {`UFCS_BW_W{1'b0}};
         tx_done_r <= 1'b0;
         txd_r <= 1'b1;
         txd_oe_r <= 1'b0;
      end
      else
      begin
         tx_done_r <= 1'b0;
         if (tx_go && !txd_oe_r)
         begin
            txd_r <= 1'b0;
            txd_oe_r <= 1'b1;
            shift_r <= {2'b11, tx_data};
            n_r <= `UFCS_TX_BITS;
            cnt_r <= bit_w - 1'b1;
         end
         else if (txd_oe_r)
         begin
            if (cnt_r != {`UFCS_BW_W{1'b0}})
               cnt_r <= cnt_r - 1'b1;
            else if (n_r == 4'h0)
            begin
               txd_oe_r <= 1'b0;
               tx_done_r <= 1'b1;
            end
            else
            begin
               txd_r <= shift_r[0];
               shift_r <= {1'b1, shift_r[9:1]};
               n_r <= n_r - 1'b1;
               cnt_r <= bit_w - 1'b1;
            end
         end
      end
   end
endmodule // ufcs_tx

// >>> ufcs_top.v
// Frame handler: sync measurement, command decode, checksums, reply
// Overview of operation
// - First field is sync; bit width is its counted length divided by eight.
// - Consecutive sync bits differing over a quarter make the frame ignored.
// - Sync byte 0x55 never enters any checksum.
// - Second field is the command; it fixes action, byte count, direction.
// - Three address bits must match the node address, else frame dropped.
// - Broadcast commands run whatever address the command byte carries.
// - Node address is zero until a stored setting is loaded.
// - Zero or one data byte follows the command, format set by command.
// - Frame ends with inverted byte sum with end-around carry.
// - Incoming checksum covers command then data and is verified here.
// - Reply checksum covers diagnostic byte then data, not the command.
// - Checksum works on whole bytes, no padding bits.
// - Badly received command is not executed; bad checksum pulses bad_cmd, framing error does not.
// - Commands 0-3 take object count 1-8 and get no reply.
// - Command 4 byte 0 starts temperature, 1 noise; others unused.
// - Command 5 replies four bytes per object: time MSB, LSB, width, peak.
// - Bytes: one start, eight data, two stop, no parity, auto baud.
// - One bit time separates incoming fields and precedes the reply; reply bytes go out back to back.
// - Transmit only as a reply to a received command.
`timescale 1ns/1ps
`include "ufcs_defs.vh"
module ufcs_top #(
   parameter [`UFCS_IDLE_W-1:0] IDLE_CYC = `UFCS_IDLE_CYC
) (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Serial line
   input wire rxd,
   output wire txd,
   output wire txd_oe,
   // Node address setting
   input wire addr_wr,
   input wire [2:0] addr_in,
   // Measurement requests
   output wire meas_start,
   output wire [1:0] meas_mode,
   output wire [3:0] meas_objs,
   output wire tn_start,
   output wire tn_sel,
   output wire bad_cmd,
   // Result readback
   input wire [3:0] obj_count,
   input wire [7:0] diag_byte,
   output wire [4:0] res_addr,
   input wire [7:0] res_data
);
   localparam S_HUNT = 4'h0;
   localparam S_SYNC = 4'h1;
   localparam S_SSTOP = 4'h2;
   localparam S_CMD = 4'h3;
   localparam S_DATA = 4'h4;
   localparam S_CKS = 4'h5;
   localparam S_IGN = 4'h6;
   localparam S_IFS = 4'h7;
   localparam S_TXW = 4'h8;
   localparam BW = `UFCS_BW_W;

   function [7:0] cks_add;
      input [7:0] a;
      input [7:0] b;
      reg [8:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         cks_add = s[7:0] + {7'h00, s[8]};
      end
   endfunction

   function bw_bad;
      input [BW-1:0] a;
      input [BW-1:0] b;
      reg [BW-1:0] d;
      begin
         d = (a > b) ? a - b : b - a;
         bw_bad = {d, 2'b00} > {2'b00, b};
      end
   endfunction

   reg rxd_m_r;
   reg rxd_s_r;
   reg rxd_d_r;
   reg [3:0] st_r;
   reg [3:0] e_r;
   reg [BW-1:0] w_r;
   reg [BW-1:0] pw_r;
   reg [`UFCS_TOT_W-1:0] tot_r;
   reg [BW-1:0] bit_w_r;
   reg [`UFCS_IDLE_W-1:0] idle_r;
   reg [2:0] node_addr_r;
   reg [7:0] cmd_r;
   reg [7:0] data_r;
   reg [7:0] sum_r;
   reg [5:0] tx_idx_r;
   reg cks_sent_r;
   reg tx_go_r;
   reg [7:0] tx_byte_r;
   reg meas_start_r;
   reg [1:0] meas_mode_r;
   reg [3:0] meas_objs_r;
   reg tn_start_r;
   reg tn_sel_r;
   reg bad_cmd_r;

   wire edge_w = rxd_s_r ^ rxd_d_r;
   wire fall_w = rxd_d_r & ~rxd_s_r;
   wire rx_en = (st_r == S_CMD) || (st_r == S_DATA) || (st_r == S_CKS);
   wire tx_on = (st_r == S_IFS) || (st_r == S_TXW);
   wire [7:0] rx_data;
   wire rx_vld;
   wire rx_ferr;
   wire tx_done;
   wire [4:0] code_w = rx_data[4:0];
   wire [4:0] ccode = cmd_r[4:0];
   wire is_bc_w = (code_w >= `UFCS_CMD_BC_FIRST) && (code_w <= `UFCS_CMD_BC_LAST);
   wire is_bc_c = (ccode >= `UFCS_CMD_BC_FIRST) && (ccode <= `UFCS_CMD_BC_LAST);
   wire [4:0] mcode = is_bc_c ? ccode - `UFCS_CMD_BC_FIRST : ccode;
   wire [3:0] obj_n = (obj_count > `UFCS_OBJ_CAP) ? `UFCS_OBJ_CAP : obj_count;
   wire [5:0] nbytes = {obj_n, 2'b00};
   // Mid-stop sample plus 2.5 bits clears both stop bits and the field gap
   // Legal rates keep the doubled width inside the counter
   wire [BW-1:0] gap_w = {bit_w_r[BW-2:0], 1'b0} + {1'b0, bit_w_r[BW-1:1]};

   assign meas_start = meas_start_r;
   assign meas_mode = meas_mode_r;
   assign meas_objs = meas_objs_r;
   assign tn_start = tn_start_r;
   assign tn_sel = tn_sel_r;
   assign bad_cmd = bad_cmd_r;
   assign res_addr = tx_idx_r[4:0];

   ufcs_rx u_rx (
      .core_clk(core_clk),
      .resetn(resetn),
      .en(rx_en),
      .rxd_s(rxd_s_r),
      .bit_w(bit_w_r),
      .rx_data_r(rx_data),
      .rx_vld_r(rx_vld),
      .rx_ferr_r(rx_ferr)
   );

   ufcs_tx u_tx (
      .core_clk(core_clk),
      .resetn(resetn),
      .tx_go(tx_go_r),
      .tx_data(tx_byte_r),
      .bit_w(bit_w_r),
      .tx_done_r(tx_done),
      .txd_r(txd),
      .txd_oe_r(txd_oe)
   );

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rxd_m_r <= 1'b1;
         rxd_s_r <= 1'b1;
         rxd_d_r <= 1'b1;
         node_addr_r <= `UFCS_ADDR_RST;
         idle_r <= {`UFCS_IDLE_W{1'b0}};
      end
      else
      begin
         rxd_m_r <= rxd;
         rxd_s_r <= rxd_m_r;
         rxd_d_r <= rxd_s_r;
         if (addr_wr)
            node_addr_r <= addr_in;
         // Own reply must not count as idle line time
         if (edge_w || tx_on || idle_r == IDLE_CYC)
            idle_r <= {`UFCS_IDLE_W{1'b0}};
         else
            idle_r <= idle_r + 1'b1;
      end
   end

   always @(posedge core_clk or negedge resetn)
   begin
      if (!resetn)
      begin
         st_r <= S_HUNT;
         e_r <= 4'h0;
         w_r <= {BW{1'b0}};
         pw_r <= {BW{1'b0}};
         tot_r <= {`UFCS_TOT_W{1'b0}};
         bit_w_r <= {BW{1'b1}};
         cmd_r <= 8'h00;
         data_r <= 8'h00;
         sum_r <= 8'h00;
         tx_idx_r <= 6'h00;
         cks_sent_r <= 1'b0;
         tx_go_r <= 1'b0;
         tx_byte_r <= 8'h00;
         meas_start_r <= 1'b0;
         meas_mode_r <= 2'h0;
         meas_objs_r <= 4'h0;
         tn_start_r <= 1'b0;
         tn_sel_r <= 1'b0;
         bad_cmd_r <= 1'b0;
      end
      else
      begin
         tx_go_r <= 1'b0;
         meas_start_r <= 1'b0;
         tn_start_r <= 1'b0;
         bad_cmd_r <= 1'b0;
         if (idle_r == IDLE_CYC && !tx_on)
            st_r <= S_HUNT;
         else
            case (st_r)
               S_HUNT:
                  if (fall_w)
                  begin
                     w_r <= {{(BW-1){1'b0}}, 1'b1};
                     e_r <= 4'h0;
                     tot_r <= {`UFCS_TOT_W{1'b0}};
                     st_r <= S_SYNC;
                  end
               S_SYNC:
                  if (edge_w)
                  begin
                     e_r <= e_r + 1'b1;
                     pw_r <= w_r;
                     w_r <= {{(BW-1){1'b0}}, 1'b1};
                     if (e_r != 4'h0)
                        tot_r <= tot_r + {{(`UFCS_TOT_W-BW){1'b0}}, w_r};
                     if (e_r != 4'h0 && bw_bad(w_r, pw_r))
                        st_r <= S_IGN;
                     else if (e_r == `UFCS_SYNC_LAST)
                        st_r <= S_SSTOP;
                  end
                  else if (w_r == {BW{1'b1}})
                     st_r <= S_IGN;
                  else
                     w_r <= w_r + 1'b1;
               S_SSTOP:
                  // Two stop bits always give a full high bit here
                  if (fall_w)
                     st_r <= S_IGN;
                  else if (w_r == pw_r)
                  begin
                     bit_w_r <= tot_r[`UFCS_DIV_SHIFT+BW-1:`UFCS_DIV_SHIFT];
                     st_r <= S_CMD;
                  end
                  else
                     w_r <= w_r + 1'b1;
               S_CMD:
                  if (rx_ferr)
                     st_r <= S_IGN;
                  else if (rx_vld)
                  begin
                     cmd_r <= rx_data;
                     sum_r <= rx_data;
                     if (code_w > `UFCS_CMD_RES && !is_bc_w)
                        st_r <= S_IGN;
                     else if (rx_data[7:5] != node_addr_r && !is_bc_w)
                        st_r <= S_IGN;
                     else if (code_w == `UFCS_CMD_RES)
                        st_r <= S_CKS;
                     else
                        st_r <= S_DATA;
                  end
               S_DATA:
                  if (rx_ferr)
                     st_r <= S_IGN;
                  else if (rx_vld)
                  begin
                     data_r <= rx_data;
                     sum_r <= cks_add(sum_r, rx_data);
                     st_r <= S_CKS;
                  end
               S_CKS:
                  if (rx_ferr)
                     st_r <= S_IGN;
                  else if (rx_vld)
                  begin
                     st_r <= S_HUNT;
                     w_r <= {BW{1'b0}};
                     if (rx_data != ~sum_r)
                        bad_cmd_r <= 1'b1;
                     else if (mcode <= `UFCS_CMD_LO2)
                     begin
                        if (data_r >= `UFCS_OBJ_MIN && data_r <= `UFCS_OBJ_MAX)
                        begin
                           meas_start_r <= 1'b1;
                           meas_mode_r <= mcode[1:0];
                           meas_objs_r <= data_r[3:0];
                        end
                        else
                           bad_cmd_r <= 1'b1;
                     end
                     else if (mcode == `UFCS_CMD_TN)
                     begin
                        if (data_r <= `UFCS_TN_MAX)
                        begin
                           tn_start_r <= 1'b1;
                           tn_sel_r <= data_r[0];
                        end
                        else
                           bad_cmd_r <= 1'b1;
                     end
                     else
                        st_r <= S_IFS;
                  end
               S_IGN:
                  st_r <= S_IGN;
               S_IFS:
                  if (w_r == gap_w)
                  begin
                     tx_byte_r <= diag_byte;
                     sum_r <= diag_byte;
                     tx_idx_r <= 6'h00;
                     cks_sent_r <= 1'b0;
                     tx_go_r <= 1'b1;
                     st_r <= S_TXW;
                  end
                  else
                     w_r <= w_r + 1'b1;
               S_TXW:
                  if (tx_done)
                  begin
                     if (tx_idx_r < nbytes)
                     begin
                        // Core serves time MSB, LSB, width, peak per object
                        tx_byte_r <= res_data;
                        sum_r <= cks_add(sum_r, res_data);
                        tx_idx_r <= tx_idx_r + 1'b1;
                        tx_go_r <= 1'b1;
                     end
                     else if (!cks_sent_r)
                     begin
                        tx_byte_r <= ~sum_r;
                        cks_sent_r <= 1'b1;
                        tx_go_r <= 1'b1;
                     end
                     else
                        st_r <= S_HUNT;
                  end
               default:
                  st_r <= S_HUNT;
            endcase
      end
   end
endmodule // ufcs_top

// >>> ufcs_asserts.sv
// Checker for the reply line and request outputs of the frame handler
`timescale 1ns/1ps
module ufcs_asserts #(
   parameter [20:0] IDLE_CYC = 21'h16e360
) (
   // Clock and reset
   input wire core_clk,
   input wire resetn,
   // Serial line
   input wire txd,
   input wire txd_oe,
   // Requests
   input wire meas_start,
   input wire [1:0] meas_mode,
   input wire [3:0] meas_objs,
   input wire tn_start,
   input wire tn_sel,
   input wire bad_cmd
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!resetn);

   // A byte lasts far longer than eight cycles at any legal rate
   sequence s_start_bit;
      !txd [*8];
   endsequence
   sequence s_byte_body;
      txd_oe [*8];
   endsequence

   property p_tx_idle;
      !txd_oe |-> txd;
   endproperty
   property p_start_bit;
      $rose(txd_oe) |-> s_start_bit;
   endproperty
   property p_oe_hold;
      $rose(txd_oe) |-> s_byte_body;
   endproperty
   property p_stop_end;
      $fell(txd_oe) |-> $past(txd);
   endproperty
   property p_ms_pulse;
      meas_start |=> !meas_start;
   endproperty
   property p_tn_pulse;
      tn_start |=> !tn_start;
   endproperty
   property p_objs;
      meas_start |-> (meas_objs >= 4'h1 && meas_objs <= 4'h8);
   endproperty
   property p_bad_excl;
      bad_cmd |-> !meas_start && !tn_start;
   endproperty
   property p_mode_hold;
      !$stable({meas_mode, meas_objs}) |-> meas_start;
   endproperty
   property p_sel_hold;
      !$stable(tn_sel) |-> tn_start;
   endproperty
   property p_quiet;
      (meas_start || tn_start) |-> !txd_oe;
   endproperty

   a_tx_idle: assert property (p_tx_idle)
      else $error("txd low while not driving");
   a_start_bit: assert property (p_start_bit)
      else $error("reply byte without a full start bit");
   a_oe_hold: assert property (p_oe_hold)
      else $error("txd_oe dropped inside a byte");
   a_stop_end: assert property (p_stop_end)
      else $error("reply byte not closed by stop level");
   a_ms_pulse: assert property (p_ms_pulse)
      else $error("meas_start longer than one cycle");
   a_tn_pulse: assert property (p_tn_pulse)
      else $error("tn_start longer than one cycle");
   a_objs: assert property (p_objs)
      else $error("object count out of range");
   a_bad_excl: assert property (p_bad_excl)
      else $error("rejected command still executed");
   a_mode_hold: assert property (p_mode_hold)
      else $error("meas settings changed without request");
   a_sel_hold: assert property (p_sel_hold)
      else $error("tn_sel changed without request");
   a_quiet: assert property (p_quiet)
      else $error("reply during no-reply command");
endmodule // ufcs_asserts

bind ufcs_top ufcs_asserts #(.IDLE_CYC(IDLE_CYC)) ufcs_asserts_inst (.core_clk(core_clk),
   .resetn(resetn), .txd(txd), .txd_oe(txd_oe), .meas_start(meas_start),
   .meas_mode(meas_mode), .meas_objs(meas_objs), .tn_start(tn_start), .tn_sel(tn_sel),
   .bad_cmd(bad_cmd));

// >>> ufcs_mst.sv
// Master controller model: frames out on rxd, reply bytes in from txd
`timescale 1ns/1ps
module ufcs_mst #(
   parameter W = 20
) (
   // Clock
   input wire core_clk,
   // Line
   input wire txd,
   input wire txd_oe,
   output reg rxd
);
   // Line idles at the pull-up level
   initial rxd = 1'b1;

   function [7:0] add_c(input [7:0] a, input [7:0] b);
      reg [8:0] s;
      begin
         s = {1'b0, a} + {1'b0, b};
         add_c = s[7:0] + {7'h00, s[8]};
      end
   endfunction

   task bit_out(input b, input integer n);
      begin
         rxd = b;
         repeat (n) @(posedge core_clk);
         #1;
      end
   endtask

   task byte_out(input [7:0] d, input integer w3);
      integer i;
      begin
         bit_out(1'b0, W);
         for (i = 0; i < 8; i = i + 1)
            bit_out(d[i], (i == 3) ? w3 : W);
         bit_out(1'b1, 3 * W); // two stop bits, one bit of wait
      end
   endtask

   task frame(input [7:0] cmd, input [7:0] d, input has_d, input [7:0] cs_err,
      input bad_sync);
      reg [7:0] cs;
      begin
         cs = ~(has_d ? add_c(cmd, d) : cmd) ^ cs_err;
         byte_out(8'h55, bad_sync ? 2 * W : W);
         byte_out(cmd, W);
         if (has_d)
            byte_out(d, W);
         byte_out(cs, W);
      end
   endtask

   // Samples mid-bit on falling edges, clear of the design's updates
   task get_byte(output [7:0] d, output ok);
      integer i;
      begin
         i = 0;
         while (!(txd_oe === 1'b1 && txd === 1'b0) && i < 2000)
         begin
            @(negedge core_clk);
            i = i + 1;
         end
         repeat (W / 2) @(negedge core_clk);
         ok = (txd === 1'b0);
         for (i = 0; i < 8; i = i + 1)
         begin
            repeat (W) @(negedge core_clk);
            d[i] = txd;
         end
         repeat (W) @(negedge core_clk);
         ok = ok && (txd === 1'b1);
         repeat (W) @(negedge core_clk);
         ok = ok && (txd === 1'b1);
      end
   endtask
endmodule // ufcs_mst

// >>> ufcs_top_tb.sv
// Self-checking bench for the frame command slave
`timescale 1ns/1ps
module ufcs_top_tb;
   localparam W = 20;
   localparam IDLE = 5000;
   reg core_clk = 1'b0;
   reg resetn = 1'b0;
   reg addr_wr = 1'b0;
   reg [2:0] addr_in = 3'h0;
   reg [3:0] obj_count = 4'h0;
   reg [7:0] diag_byte = 8'h00;
   wire rxd, txd, txd_oe, meas_start, tn_start, tn_sel, bad_cmd;
   wire [1:0] meas_mode;
   wire [3:0] meas_objs;
   wire [4:0] res_addr;
   wire [7:0] res_data = 8'ha0 ^ {3'h0, res_addr};
   integer errors = 0, n_checks = 0, n_ms = 0, n_tn = 0, n_bad = 0, n_oe = 0, cyc = 0;

   always #5 core_clk = ~core_clk;

   ufcs_top #(.IDLE_CYC(IDLE)) ufcs_top_inst (.core_clk(core_clk), .resetn(resetn),
      .rxd(rxd), .txd(txd), .txd_oe(txd_oe), .addr_wr(addr_wr), .addr_in(addr_in),
      .meas_start(meas_start), .meas_mode(meas_mode), .meas_objs(meas_objs),
      .tn_start(tn_start), .tn_sel(tn_sel), .bad_cmd(bad_cmd), .obj_count(obj_count),
      .diag_byte(diag_byte), .res_addr(res_addr), .res_data(res_data));
   ufcs_mst #(.W(W)) ufcs_mst_inst (.core_clk(core_clk), .txd(txd), .txd_oe(txd_oe),
      .rxd(rxd));

   // Pulses counted mid-cycle to stay clear of the launching edge
   always @(negedge core_clk)
   begin
      cyc = cyc + 1;
      if (meas_start === 1'b1) n_ms = n_ms + 1;
      if (tn_start === 1'b1) n_tn = n_tn + 1;
      if (bad_cmd === 1'b1) n_bad = n_bad + 1;
      if (txd_oe !== 1'b0) n_oe = n_oe + 1;
      if (cyc == 60000)
      begin
         errors = errors + 1;
         end_sim;
      end
   end

   task end_sim;
      begin
         if (errors == 0 && n_checks > 0)
            $display("DONE - PASS");
         else
            $display("DONE - FAIL");
         $finish;
      end
   endtask

   task chk(input string nm, input [7:0] got, input [7:0] want);
      begin
         n_checks = n_checks + 1;
         if (got !== want)
         begin
            errors = errors + 1;
            $display("BAD %0s expected %h seen %h", nm, want, got);
         end
      end
   endtask

   task sent(input [7:0] cmd, input [7:0] d, input has_d, input [7:0] cs_err,
      input bad_sync, input [7:0] e_ms, input [7:0] e_tn, input [7:0] e_bad);
      begin
         n_ms = 0;
         n_tn = 0;
         n_bad = 0;
         n_oe = 0;
         ufcs_mst_inst.frame(cmd, d, has_d, cs_err, bad_sync);
         chk("meas_start", n_ms[7:0], e_ms);
         chk("tn_start", n_tn[7:0], e_tn);
         chk("bad_cmd", n_bad[7:0], e_bad);
         chk("txd_oe", n_oe[7:0], 8'h00);
      end
   endtask

   task idle;
      begin
         repeat (IDLE + 100) @(posedge core_clk);
         #1;
      end
   endtask

   task set_addr(input [2:0] a);
      begin
         addr_in = a;
         addr_wr = 1'b1;
         @(posedge core_clk);
         #1;
         addr_wr = 1'b0;
      end
   endtask

   task t_reset;
      begin
         chk("rst_out", {txd, txd_oe, meas_start, tn_start, bad_cmd, tn_sel, meas_mode},
            8'h80);
         chk("rst_lvl", {meas_objs, res_addr[3:0]}, 8'h00);
      end
   endtask

   // Codes 0-3 at node address zero, broadcasts 17-20 at foreign addresses
   task t_meas;
      integer c;
      reg [7:0] cmd;
      reg [7:0] n;
      begin
         for (c = 0; c < 8; c = c + 1)
         begin
            cmd = (c < 4) ? c : {c[2:0], 5'h0d + c[4:0]};
            n = c + 1;
            sent(cmd, n, 1'b1, 8'h00, 1'b0, 8'h01, 8'h00, 8'h00);
            chk("meas_mode", {6'h00, meas_mode}, {6'h00, c[1:0]});
            chk("meas_objs", {4'h0, meas_objs}, n);
         end
      end
   endtask

   task t_tn;
      begin
         sent(8'h04, 8'h00, 1'b1, 8'h00, 1'b0, 8'h00, 8'h01, 8'h00);
         chk("tn_sel", {7'h00, tn_sel}, 8'h00);
         sent(8'h04, 8'h01, 1'b1, 8'h00, 1'b0, 8'h00, 8'h01, 8'h00);
         chk("tn_sel", {7'h00, tn_sel}, 8'h01);
         sent(8'h04, 8'h02, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00, 8'h01);
         sent(8'h04, 8'hff, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00, 8'h01);
         sent(8'h00, 8'h00, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00, 8'h01);
         sent(8'h00, 8'h09, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00, 8'h01);
         sent(8'h01, 8'h03, 1'b1, 8'h01, 1'b0, 8'h00, 8'h00, 8'h01);
         chk("meas_mode", {6'h00, meas_mode}, 8'h03);
      end
   endtask

   // Ignored frames stay ignored until the line has idled out
   task t_ign;
      begin
         sent(8'h00, 8'h02, 1'b1, 8'h00, 1'b1, 8'h00, 8'h00, 8'h00);
         sent(8'h00, 8'h02, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00);
         idle;
         sent(8'h00, 8'h02, 1'b1, 8'h00, 1'b0, 8'h01, 8'h00, 8'h00);
         sent(8'h60, 8'h02, 1'b1, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00);
         idle;
         sent(8'h06, 8'h00, 1'b0, 8'h00, 1'b0, 8'h00, 8'h00, 8'h00);
         idle;
         set_addr(3'h3);
         sent(8'h60, 8'h02, 1'b1, 8'h00, 1'b0, 8'h01, 8'h00, 8'h00);
         set_addr(3'h0);
      end
   endtask

   task t_res;
      reg [7:0] got;
      reg [7:0] e;
      reg [7:0] sum;
      reg ok;
      integer k;
      begin
         obj_count = 4'h2;
         diag_byte = 8'h3c;
         sum = 8'h00;
         n_oe = 0;
         fork
            begin
               ufcs_mst_inst.frame(8'h05, 8'h00, 1'b0, 8'h00, 1'b0);
               chk("oe_early", n_oe[7:0], 8'h00);
            end
            for (k = 0; k < 10; k = k + 1)
            begin
               e = (k == 0) ? 8'h3c : 8'ha0 ^ (k - 1);
               if (k == 9)
                  e = ~sum;
               ufcs_mst_inst.get_byte(got, ok);
               chk("reply_fmt", {7'h00, ok}, 8'h01);
               chk("reply_byte", got, e);
               sum = ufcs_mst_inst.add_c(sum, e);
            end
         join
      end
   endtask

   initial
   begin
      repeat (12) @(posedge core_clk);
      #1;
      t_reset;
      resetn = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      t_meas;
      t_tn;
      t_ign;
      t_res;
      end_sim;
   end
endmodule // ufcs_top_tb
